// ---- pkg/e1_rx_defs.svh ----
// Constants for the E1 receive overhead and status report block
`ifndef E1_RX_DEFS_SVH
`define E1_RX_DEFS_SVH

// Control/status output stream channel map
`define SIG_CHAN_FIRST     5'h01
`define SIG_CHAN_LAST      5'h0F
`define FAS_CHAN           5'h10
`define NFAS_CHAN          5'h11
`define STATUS_CHAN        5'h12
`define STREAM_LAST_CHAN   5'h1F
`define STREAM_LAST_BIT    3'h7

// Line timeslots carrying overhead
`define LINE_TS_ALIGN      5'h00
`define LINE_TS_SIG        5'h10
`define LINE_LAST_FRAME    4'hF

// Status byte field positions
`define ST_FSYNC_BIT       7
`define ST_MFSYNC_BIT      6
`define ST_FASERR_BIT      5
`define ST_SLIP_BIT        4
`define ST_AIS_BIT         3
`define ST_TS16AIS_BIT     2
`define ST_EXT_BIT         1
`define ST_UNUSED_BIT      0

// Reset and idle values
`define STREAM_IDLE_BYTE   8'h00

// Alignment error supervision
`define FAS_ERR_LIMIT      16
`define FAS_HOLDOFF_MS     128
`define CORE_CLK_KHZ       125000
`define FAS_HOLDOFF_CYCLES (`FAS_HOLDOFF_MS * `CORE_CLK_KHZ)

// Stream bit rate, as an exact fraction of the core clock
`define STREAM_KBPS        2048

// All-ones alarm detection windows
`define AIS_WINDOW_BITS    512
`define AIS_ZERO_LIMIT     3

`endif

// ---- pkg/e1_rx_pkg.sv ----
// Types shared by the E1 receive overhead and status report block
package e1_rx_pkg;
   typedef logic [7:0] byte_t;    // One stream or line byte
   typedef logic [4:0] chan_t;    // Channel or timeslot number
   typedef logic [2:0] bitpos_t;  // Bit position, 0 is the first bit sent
   typedef logic [3:0] frame_t;   // Frame number within a multiframe
endpackage : e1_rx_pkg

// ---- core/e1_rx_stream_timer.sv ----
// Bit, channel and frame timing of the 2048 kbit/s output stream
`timescale 1ns/10ps
`include "e1_rx_defs.svh"
module e1_rx_stream_timer
   import e1_rx_pkg::*;
#(
   parameter int CLK_KHZ  = `CORE_CLK_KHZ,
   parameter int BIT_KBPS = `STREAM_KBPS
) (
   // Clock and reset
   input  wire logic    clk,
   input  wire logic    rst,
   // Stream position
   output logic         bit_tick,
   output chan_t        chan,
   output bitpos_t      bitpos
);

   // The 18-bit phase accumulator must hold the clock rate plus one step
   if (BIT_KBPS < 1 || BIT_KBPS > CLK_KHZ / 2 ||
       CLK_KHZ > 131071) begin : bad_rate
      $error("clock rate up to 131071 kHz, bit rate up to half of it");
   end

   logic [17:0] acc_reg;        // Fractional phase accumulator
   logic [17:0] acc_sum;        // Phase after this cycle's step
   chan_t       chan_reg;       // Current channel
   bitpos_t     bit_reg;        // Current bit within the channel

   // Exact rate: one tick each time the phase passes the clock rate
   assign acc_sum  = acc_reg + 18'(BIT_KBPS);
   assign bit_tick = acc_sum >= 18'(CLK_KHZ);
   assign chan     = chan_reg;
   assign bitpos   = bit_reg;

   // Phase accumulator
   always_ff @(posedge clk) begin
      if (rst) begin
         acc_reg <= 18'h00000;
      end else if (bit_tick) begin
         acc_reg <= acc_sum - 18'(CLK_KHZ);
      end else begin
         acc_reg <= acc_sum;
      end
   end

   // Bit counter advances once per tick, channel counter on the tick after bit 7, wrapping per frame
   always_ff @(posedge clk) begin
      if (rst) begin
         bit_reg  <= 3'h0;
         chan_reg <= 5'h00;
      end else if (bit_tick) begin
         bit_reg <= bit_reg + 3'h1;
         if (bit_reg == `STREAM_LAST_BIT) begin
            chan_reg <= chan_reg + 5'h01;
         end
      end
   end

endmodule : e1_rx_stream_timer

// ---- core/e1_rx_fas_error_monitor.sv ----
// Counts alignment word errors and toggles a flag with a hold-off time
`timescale 1ns/10ps
`include "e1_rx_defs.svh"
module e1_rx_fas_error_monitor #(
   parameter int ERR_LIMIT      = `FAS_ERR_LIMIT,
   parameter int HOLDOFF_CYCLES = `FAS_HOLDOFF_CYCLES
) (
   // Clock and reset
   input  wire logic clk,
   input  wire logic rst,
   // Error event from the frame aligner
   input  wire logic fas_err,
   // Toggling error flag
   output logic      err_toggle
);

   // The hold-off counter is 25 bits wide and is loaded with the count less one
   if (ERR_LIMIT < 1 || ERR_LIMIT > 255 ||
       HOLDOFF_CYCLES < 1 || HOLDOFF_CYCLES > 33554432) begin : bad_cfg
      $error("error limit must be 1..255 and hold-off 1..33554432 cycles");
   end

   logic [7:0]  err_cnt_reg;    // Errors since the last toggle, saturating
   logic [24:0] hold_cnt_reg;   // Cycles left before another toggle
   logic        toggle_reg;     // Reported flag
   logic        limit_hit;      // Enough errors counted
   logic        hold_done;      // Hold-off has expired
   logic        do_toggle;      // Toggle in this cycle

   assign limit_hit  = err_cnt_reg >= 8'(ERR_LIMIT);
   assign hold_done  = hold_cnt_reg == 25'h0000000;
   assign do_toggle  = limit_hit && hold_done;
   assign err_toggle = toggle_reg;

   // Error counter restarts at each toggle; an error in that cycle counts
   always_ff @(posedge clk) begin
      if (rst) begin
         err_cnt_reg <= 8'h00;
      end else if (do_toggle) begin
         err_cnt_reg <= {7'h00, fas_err};
      end else if (fas_err && err_cnt_reg != 8'hFF) begin
         err_cnt_reg <= err_cnt_reg + 8'h01;
      end
   end

   // Hold-off timer and flag toggle, at most once per hold-off time
   always_ff @(posedge clk) begin
      if (rst) begin
         hold_cnt_reg <= 25'h0000000;
         toggle_reg   <= 1'b0;
      end else if (do_toggle) begin
         hold_cnt_reg <= 25'(HOLDOFF_CYCLES - 1);
         toggle_reg   <= ~toggle_reg;
      end else if (!hold_done) begin
         hold_cnt_reg <= hold_cnt_reg - 25'h0000001;
      end
   end

endmodule : e1_rx_fas_error_monitor

// ---- core/e1_rx_overhead_status_report.sv ----
// E1 receive overhead capture and control/status output stream
`timescale 1ns/10ps
`include "e1_rx_defs.svh"
module e1_rx_overhead_status_report
   import e1_rx_pkg::*;
#(
   parameter int FAS_ERR_LIMIT      = `FAS_ERR_LIMIT,
   parameter int FAS_HOLDOFF_CYCLES = `FAS_HOLDOFF_CYCLES,
   parameter int AIS_WINDOW_BITS    = `AIS_WINDOW_BITS,
   parameter int AIS_ZERO_LIMIT     = `AIS_ZERO_LIMIT
) (
   // Clock and reset
   input  wire logic    CORE_CLK,
   input  wire logic    RST,
   // Recovered receive line bits with their frame position
   input  wire logic    LINE_BIT,
   input  wire logic    LINE_BIT_VALID,
   input  wire chan_t   LINE_TS,
   input  wire bitpos_t LINE_BIT_POS,
   input  wire frame_t  LINE_FRAME,
   input  wire logic    LINE_FAS_FRAME,
   // Receive framer state and events
   input  wire logic    FRAME_SYNC_OK,
   input  wire logic    MFRAME_SYNC_OK,
   input  wire logic    FAS_WORD_ERR,
   input  wire logic    SLIP_EVENT,
   // External status pin, asynchronous
   input  wire logic    EXT_STATUS,
   // Control/status output stream
   output logic         CTRL_STATUS_OUT_STREAM,
   output logic         CTRL_FRAME_PULSE
);

   if (AIS_WINDOW_BITS < 2 || AIS_WINDOW_BITS > 1023 ||
       AIS_ZERO_LIMIT < 1 || AIS_ZERO_LIMIT > AIS_WINDOW_BITS) begin : bad_ais
      $error("alarm window must be 2..1023 bits with a limit inside it");
   end

   // Channels 1 to 15 carry the received signalling bytes
   function automatic logic is_sig_chan(input chan_t c);
      is_sig_chan = (c >= `SIG_CHAN_FIRST) && (c <= `SIG_CHAN_LAST);
   endfunction : is_sig_chan

   // ---------------------------------------------------------------
   // Line byte assembly
   // ---------------------------------------------------------------
   byte_t   rx_shift_reg;          // Bits of the timeslot so far
   byte_t   rx_byte;               // Complete byte, first bit in bit 7
   logic    byte_done;             // Last bit of a timeslot arrives
   logic    at_sig_ts;             // Byte is from timeslot 16
   logic    at_align_ts;           // Byte is from timeslot 0
   chan_t   line_frame_chan;       // Frame number as a stream channel
   logic    sig_write;             // Store a signalling byte
   logic    fas_write;             // Store an aligned frame ts0 byte
   logic    nfas_write;            // Store a non-aligned frame ts0 byte

   assign rx_byte         = {rx_shift_reg[6:0], LINE_BIT};
   assign byte_done       = LINE_BIT_VALID && LINE_BIT_POS == `STREAM_LAST_BIT;
   assign at_sig_ts       = LINE_TS == `LINE_TS_SIG;
   assign at_align_ts     = LINE_TS == `LINE_TS_ALIGN;
   assign line_frame_chan = {1'b0, LINE_FRAME};
   assign sig_write  = byte_done && at_sig_ts && is_sig_chan(line_frame_chan);
   assign fas_write  = byte_done && at_align_ts && LINE_FAS_FRAME;
   assign nfas_write = byte_done && at_align_ts && !LINE_FAS_FRAME;

   // Shift received bits in, first bit of the timeslot ends in bit 7
   always_ff @(posedge CORE_CLK) begin
      if (RST) begin
         rx_shift_reg <= `STREAM_IDLE_BYTE;
      end else if (LINE_BIT_VALID) begin
         rx_shift_reg <= rx_byte;
      end
   end

   // ---------------------------------------------------------------
   // Overhead byte stores
   // ---------------------------------------------------------------
   byte_t   sig_mem [1:15];        // Signalling bytes, one per frame
   byte_t   fas_reg;               // Aligned frame timeslot 0
   byte_t   nfas_reg;              // Non-aligned frame timeslot 0

   // Signalling store: ABCD of channel N high, of channel N+15 low
   always_ff @(posedge CORE_CLK) begin
      if (RST) begin
         for (int i = 1; i <= 15; i++) begin
            sig_mem[i] <= `STREAM_IDLE_BYTE;
         end
      end else if (sig_write) begin
         sig_mem[LINE_FRAME] <= rx_byte;
      end
   end

   // Timeslot 0 stores, chosen by frame type
   always_ff @(posedge CORE_CLK) begin
      if (RST) begin
         fas_reg  <= `STREAM_IDLE_BYTE;
         nfas_reg <= `STREAM_IDLE_BYTE;
      end else begin
         if (fas_write) begin
            fas_reg <= rx_byte;
         end
         if (nfas_write) begin
            nfas_reg <= rx_byte;
         end
      end
   end

   // ---------------------------------------------------------------
   // All-ones alarm detection on the whole line
   // ---------------------------------------------------------------
   logic [9:0] ais_bit_cnt_reg;    // Bits seen in the current window
   logic [9:0] ais_zero_cnt_reg;   // Zeros seen in the current window
   logic [9:0] ais_zero_next;      // Zero count including this bit
   logic       ais_window_end;     // Last bit of the window
   logic       ais_reg;            // Line alarm flag

   assign ais_zero_next  = ais_zero_cnt_reg + {9'h000, ~LINE_BIT};
   assign ais_window_end = LINE_BIT_VALID &&
                           ais_bit_cnt_reg == 10'(AIS_WINDOW_BITS - 1);

   // Window of line bits: alarm while too few zeros are seen
   always_ff @(posedge CORE_CLK) begin
      if (RST) begin
         ais_bit_cnt_reg  <= 10'h000;
         ais_zero_cnt_reg <= 10'h000;
         ais_reg          <= 1'b0;
      end else if (ais_window_end) begin
         ais_bit_cnt_reg  <= 10'h000;
         ais_zero_cnt_reg <= 10'h000;
         ais_reg <= ais_zero_next < 10'(AIS_ZERO_LIMIT);
      end else if (LINE_BIT_VALID) begin
         ais_bit_cnt_reg  <= ais_bit_cnt_reg + 10'h001;
         ais_zero_cnt_reg <= ais_zero_next;
      end
   end

   // ---------------------------------------------------------------
   // All-ones alarm detection in timeslot 16, per multiframe
   // ---------------------------------------------------------------
   logic ts16_zero_seen_reg;       // A zero arrived in ts16 this multiframe
   logic ts16_bit;                 // Current bit belongs to ts16
   logic ts16_mf_end;              // Last ts16 bit of the multiframe
   logic ais16_reg;                // Timeslot 16 alarm flag

   assign ts16_bit    = LINE_BIT_VALID && at_sig_ts;
   assign ts16_mf_end = ts16_bit && LINE_BIT_POS == `STREAM_LAST_BIT &&
                        LINE_FRAME == `LINE_LAST_FRAME;

   // Alarm while a whole multiframe of ts16 carried only ones
   always_ff @(posedge CORE_CLK) begin
      if (RST) begin
         ts16_zero_seen_reg <= 1'b0;
         ais16_reg          <= 1'b0;
      end else if (ts16_mf_end) begin
         ts16_zero_seen_reg <= 1'b0;
         ais16_reg <= !(ts16_zero_seen_reg || !LINE_BIT);
      end else if (ts16_bit && !LINE_BIT) begin
         ts16_zero_seen_reg <= 1'b1;
      end
   end

   // ---------------------------------------------------------------
   // Sync, slip and alignment error flags
   // ---------------------------------------------------------------
   logic fsync_lost_reg;           // Frame alignment lost
   logic mfsync_lost_reg;          // Multiframe alignment lost
   logic slip_toggle_reg;          // Flips on each controlled slip
   logic fas_err_toggle;           // Flips on repeated alignment errors

   // Loss flags follow the framer state, slips flip a bit
   always_ff @(posedge CORE_CLK) begin
      if (RST) begin
         fsync_lost_reg  <= 1'b0;
         mfsync_lost_reg <= 1'b0;
         slip_toggle_reg <= 1'b0;
      end else begin
         fsync_lost_reg  <= !FRAME_SYNC_OK;
         mfsync_lost_reg <= !MFRAME_SYNC_OK;
         if (SLIP_EVENT) begin
            slip_toggle_reg <= ~slip_toggle_reg;
         end
      end
   end

   // Alignment error supervision with its hold-off time
   e1_rx_fas_error_monitor #(
      .ERR_LIMIT      (FAS_ERR_LIMIT),
      .HOLDOFF_CYCLES (FAS_HOLDOFF_CYCLES)
   ) u_fas_err (
      .clk        (CORE_CLK),
      .rst        (RST),
      .fas_err    (FAS_WORD_ERR),
      .err_toggle (fas_err_toggle)
   );

   // ---------------------------------------------------------------
   // External status pin
   // ---------------------------------------------------------------
   logic ext_meta_reg;             // First synchroniser stage
   logic ext_sync_reg;             // Second synchroniser stage
   logic ext_sample_reg;           // Value taken at the frame start

   // Two-stage synchroniser for the asynchronous pin
   always_ff @(posedge CORE_CLK) begin
      if (RST) begin
         ext_meta_reg <= 1'b0;
         ext_sync_reg <= 1'b0;
      end else begin
         ext_meta_reg <= EXT_STATUS;
         ext_sync_reg <= ext_meta_reg;
      end
   end

   // ---------------------------------------------------------------
   // Output stream timing and serialiser
   // ---------------------------------------------------------------
   logic    tmr_tick;              // One pulse per stream bit
   chan_t   tmr_chan;              // Channel of the bit being sent
   bitpos_t tmr_bit;               // Bit of the channel being sent
   logic    frame_start;           // First bit of a stream frame
   byte_t   status_byte;           // Receive status flags byte
   byte_t   out_byte;              // Byte of the current channel
   bitpos_t out_index;             // Byte bit sent now, MSB first
   logic    stream_bit_reg;        // Serial output flop
   logic    frame_pulse_reg;       // Frame pulse flop

   e1_rx_stream_timer #(
      .CLK_KHZ  (`CORE_CLK_KHZ),
      .BIT_KBPS (`STREAM_KBPS)
   ) u_timer (
      .clk      (CORE_CLK),
      .rst      (RST),
      .bit_tick (tmr_tick),
      .chan     (tmr_chan),
      .bitpos   (tmr_bit)
   );

   assign frame_start = tmr_tick && tmr_chan == 5'h00 && tmr_bit == 3'h0;
   assign out_index   = `STREAM_LAST_BIT - tmr_bit;

   // Status byte, unused bit tied low
   assign status_byte = {fsync_lost_reg,
                         mfsync_lost_reg,
                         fas_err_toggle,
                         slip_toggle_reg,
                         ais_reg,
                         ais16_reg,
                         ext_sample_reg,
                         1'b0};

   // Channel selection; channels without a source send the idle byte
   assign out_byte =
      is_sig_chan(tmr_chan)      ? sig_mem[tmr_chan[3:0]] :
      (tmr_chan == `FAS_CHAN)    ? fas_reg     :
      (tmr_chan == `NFAS_CHAN)   ? nfas_reg    :
      (tmr_chan == `STATUS_CHAN) ? status_byte :
      `STREAM_IDLE_BYTE;

   // External status taken once per stream frame
   always_ff @(posedge CORE_CLK) begin
      if (RST) begin
         ext_sample_reg <= 1'b0;
      end else if (frame_start) begin
         ext_sample_reg <= ext_sync_reg;
      end
   end

   // Serial output: one bit per tick, frame pulse on the first bit
   always_ff @(posedge CORE_CLK) begin
      if (RST) begin
         stream_bit_reg  <= 1'b0;
         frame_pulse_reg <= 1'b0;
      end else begin
         frame_pulse_reg <= frame_start;
         if (tmr_tick) begin
            stream_bit_reg <= out_byte[out_index];
         end
      end
   end

   assign CTRL_STATUS_OUT_STREAM = stream_bit_reg;
   assign CTRL_FRAME_PULSE       = frame_pulse_reg;

endmodule : e1_rx_overhead_status_report

// ---- tb/e1_rx_line_model.sv ----
// Remote trunk model presenting received line bits to the block
`timescale 1ns/10ps
module e1_rx_line_model
   import e1_rx_pkg::*;
(
   // Clock
   input  wire logic clk,
   // Line bits with their frame position
   output logic      line_bit,
   output logic      line_bit_valid,
   output chan_t     line_ts,
   output bitpos_t   line_bit_pos,
   output frame_t    line_frame,
   output logic      line_fas_frame
);
   // Quiet line at time zero
   initial begin
      line_bit       = 1'b0;
      line_bit_valid = 1'b0;
      line_ts        = 5'h00;
      line_bit_pos   = 3'h0;
      line_frame     = 4'h0;
      line_fas_frame = 1'b0;
   end

   // Sends one timeslot byte, first bit first, a bit every other cycle
   task automatic send_byte(input chan_t ts, input frame_t fr,
                            input logic fas, input byte_t data);
      byte_t tx;
      tx = data;
      // Signalling nibbles are never all zero; spare B C D sent as 1 0 1
      if (ts == 5'h10 && fr != 4'h0) begin
         if (tx[7:4] == 4'h0) tx[7:4] = 4'hD;
         if (tx[3:0] == 4'h0) tx[3:0] = 4'hD;
      end
      for (int i = 0; i < 8; i++) begin
         @(posedge clk);
         line_bit       <= tx[7-i];
         line_bit_valid <= 1'b1;
         line_ts        <= ts;
         line_bit_pos   <= bitpos_t'(i);
         line_frame     <= fr;
         line_fas_frame <= fas;
         @(posedge clk);
         line_bit_valid <= 1'b0;
         // A released bit shows its inverse, never a stale value
         line_bit       <= ~tx[7-i];
      end
   endtask : send_byte
endmodule : e1_rx_line_model

// ---- tb/e1_rx_overhead_status_report_props.sv ----
// Checker of the status stream timing and fixed fields
`timescale 1ns/10ps
module e1_rx_report_props (
   // Clock and reset
   input wire logic CORE_CLK,
   input wire logic RST,
   // Framer state
   input wire logic FRAME_SYNC_OK,
   input wire logic MFRAME_SYNC_OK,
   // Control/status output stream
   input wire logic STREAM_BIT,
   input wire logic FRAME_PULSE
);
   int   cnt;   // Cycles since the last frame pulse
   int   k;     // Stream bit now sampled
   int   quiet; // Cycles since framer state last moved
   logic seen;  // A frame pulse has been seen
   logic fs_q;  // Framer state one cycle back
   logic mf_q;
   logic smp;   // Mid-bit sample point of bit k
   logic qok;   // Framer state steady long enough

   // Sample 30 cycles into each 61 or 62 cycle bit
   assign smp = seen && (cnt == (k * 125000) / 2048 + 30);
   assign qok = (quiet >= 9000);

   // Stream position follows the frame pulse
   always_ff @(posedge CORE_CLK) begin
      fs_q <= FRAME_SYNC_OK;
      mf_q <= MFRAME_SYNC_OK;
      if (RST) begin
         cnt  <= 0;
         k    <= 0;
         seen <= 1'b0;
      end else if (FRAME_PULSE) begin
         cnt  <= 1;
         k    <= 0;
         seen <= 1'b1;
      end else begin
         cnt <= cnt + 1;
         if (smp) k <= k + 1;
      end
      // Restart the steady count on any framer change
      if (RST || fs_q != FRAME_SYNC_OK || mf_q != MFRAME_SYNC_OK) quiet <= 0;
      else if (quiet < 9000) quiet <= quiet + 1;
   end

   sequence s_gap;
      !FRAME_PULSE [*8];
   endsequence
   property p_reset_idle;
      @(posedge CORE_CLK) RST |=> !STREAM_BIT && !FRAME_PULSE;
   endproperty
   property p_pulse_gap;
      @(posedge CORE_CLK) disable iff (RST) FRAME_PULSE |=> s_gap;
   endproperty
   property p_period;
      @(posedge CORE_CLK) disable iff (RST)
         (FRAME_PULSE && seen) |-> cnt == 15625;
   endproperty
   property p_fsync;
      @(posedge CORE_CLK) disable iff (RST)
         (smp && k == 144 && qok) |-> STREAM_BIT == !FRAME_SYNC_OK;
   endproperty
   property p_mfsync;
      @(posedge CORE_CLK) disable iff (RST)
         (smp && k == 145 && qok) |-> STREAM_BIT == !MFRAME_SYNC_OK;
   endproperty
   property p_unused;
      @(posedge CORE_CLK) disable iff (RST) (smp && k == 151) |-> !STREAM_BIT;
   endproperty
   property p_ch0_zero;
      @(posedge CORE_CLK) disable iff (RST) (smp && k < 8) |-> !STREAM_BIT;
   endproperty
   property p_tail_zero;
      @(posedge CORE_CLK) disable iff (RST) (smp && k >= 152) |-> !STREAM_BIT;
   endproperty

   a_reset_idle: assert property (p_reset_idle)
      else $error("stream not idle after reset");
   a_pulse_gap: assert property (p_pulse_gap)
      else $error("frame pulse longer than one cycle");
   a_period: assert property (p_period)
      else $error("frame pulse period wrong");
   a_fsync: assert property (p_fsync)
      else $error("frame sync bit wrong");
   a_mfsync: assert property (p_mfsync)
      else $error("multiframe sync bit wrong");
   a_unused: assert property (p_unused)
      else $error("status bit 0 not zero");
   a_ch0_zero: assert property (p_ch0_zero)
      else $error("channel 0 not zero");
   a_tail_zero: assert property (p_tail_zero)
      else $error("unused channel not zero");
endmodule : e1_rx_report_props

bind e1_rx_overhead_status_report e1_rx_report_props i_props (
   .CORE_CLK(CORE_CLK), .RST(RST), .FRAME_SYNC_OK(FRAME_SYNC_OK),
   .MFRAME_SYNC_OK(MFRAME_SYNC_OK), .STREAM_BIT(CTRL_STATUS_OUT_STREAM),
   .FRAME_PULSE(CTRL_FRAME_PULSE));

// ---- tb/e1_rx_overhead_status_report_tb_top.sv ----
// Testbench for the E1 receive overhead and status report block
`timescale 1ns/10ps
module e1_rx_overhead_status_report_tb_top
   import e1_rx_pkg::*;
();
   logic    core_clk;         // Core clock
   logic    rst;              // Synchronous reset
   logic    line_bit;         // Line bits from the trunk model
   logic    line_bit_valid;
   chan_t   line_ts;
   bitpos_t line_bit_pos;
   frame_t  line_frame;
   logic    line_fas_frame;
   logic    frame_sync_ok;    // Framer state
   logic    mframe_sync_ok;
   logic    fas_word_err;     // Framer events
   logic    slip_event;
   logic    ext_status;       // External status pin
   logic    ctrl_status_out_stream; // Output stream
   logic    ctrl_frame_pulse;
   byte_t   got [0:18];       // Captured stream channels
   int      fails;            // Mismatches
   int      samples_checked;  // Comparisons made
   int      cycles;           // Run length

   // Short hold-off so the error flag is reachable
   e1_rx_overhead_status_report #(.FAS_HOLDOFF_CYCLES(200)) i_dut (
      .CORE_CLK(core_clk), .RST(rst), .LINE_BIT(line_bit),
      .LINE_BIT_VALID(line_bit_valid), .LINE_TS(line_ts),
      .LINE_BIT_POS(line_bit_pos), .LINE_FRAME(line_frame),
      .LINE_FAS_FRAME(line_fas_frame), .FRAME_SYNC_OK(frame_sync_ok),
      .MFRAME_SYNC_OK(mframe_sync_ok), .FAS_WORD_ERR(fas_word_err),
      .SLIP_EVENT(slip_event), .EXT_STATUS(ext_status),
      .CTRL_STATUS_OUT_STREAM(ctrl_status_out_stream),
      .CTRL_FRAME_PULSE(ctrl_frame_pulse));

   // Far-end trunk equipment
   e1_rx_line_model i_line (
      .clk(core_clk), .line_bit(line_bit), .line_bit_valid(line_bit_valid),
      .line_ts(line_ts), .line_bit_pos(line_bit_pos),
      .line_frame(line_frame), .line_fas_frame(line_fas_frame));

   // 125 MHz clock
   initial core_clk = 1'b0;
   always #4 core_clk = ~core_clk;

   // Cut a hang short
   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 50000) begin
         fails++;
         test_done();
      end
   end

   // Compares one stream byte
   task automatic chk_byte(input string nm, input int ch, input byte_t exp,
                           input byte_t act);
      samples_checked++;
      if (act !== exp) begin
         fails++;
         $display("CHECK FAILED %s ch %0d exp %h got %h", nm, ch, exp, act);
      end
   endtask : chk_byte

   // Pulses framer events, slips alongside the first errors
   task automatic events(input int errs, input int slips);
      for (int i = 0; i < errs; i++) begin
         @(posedge core_clk);
         fas_word_err <= 1'b1;
         slip_event   <= (i < slips);
         @(posedge core_clk);
         fas_word_err <= 1'b0;
         slip_event   <= 1'b0;
      end
   endtask : events

   // Captures channels 0 to 18 of the next stream frame, mid-bit
   task automatic capture();
      int k;
      int n;
      k = 0;
      n = 0;
      while (ctrl_frame_pulse !== 1'b1 && n < 20000) begin
         @(posedge core_clk);
         n++;
      end
      for (int c = 1; k < 152; c++) begin
         @(posedge core_clk);
         if (c == (k * 125000) / 2048 + 30) begin
            got[k/8][7-(k%8)] = ctrl_status_out_stream;
            k++;
         end
      end
   endtask : capture

   // Stream idles at zero with framer in sync
   task automatic test_idle();
      capture();
      for (int n = 0; n < 19; n++) begin
         chk_byte("idle", n, 8'h00, got[n]);
      end
      $display("test idle done");
   endtask : test_idle

   // Overhead bytes and first status flags
   task automatic test_overhead();
      frame_sync_ok <= 1'b0;
      ext_status    <= 1'b1;
      i_line.send_byte(5'h10, 4'h0, 1'b0, 8'hAA);
      for (int n = 1; n < 16; n++) begin
         i_line.send_byte(5'h10, frame_t'(n), 1'b0, {4'(n), 4'(16 - n)});
      end
      i_line.send_byte(5'h00, 4'h0, 1'b1, 8'h9B);
      i_line.send_byte(5'h00, 4'h1, 1'b0, 8'hDF);
      i_line.send_byte(5'h05, 4'h2, 1'b0, 8'h55);
      events(15, 1);
      capture();
      for (int n = 1; n < 16; n++) begin
         chk_byte("sig", n, {4'(n), 4'(16 - n)}, got[n]);
      end
      chk_byte("ch0", 0, 8'h00, got[0]);
      chk_byte("fas", 16, 8'h9B, got[16]);
      chk_byte("nfas", 17, 8'hDF, got[17]);
      chk_byte("status", 18, 8'h92, got[18]);
      $display("test overhead done");
   endtask : test_overhead

   // All-ones alarms, sixteenth error, second slip
   task automatic test_alarms();
      frame_sync_ok  <= 1'b1;
      mframe_sync_ok <= 1'b0;
      ext_status     <= 1'b0;
      repeat (128) i_line.send_byte(5'h05, 4'h2, 1'b0, 8'hFF);
      for (int n = 0; n < 16; n++) begin
         i_line.send_byte(5'h10, frame_t'(n), 1'b0, 8'hFF);
      end
      events(1, 1);
      capture();
      for (int n = 1; n < 16; n++) begin
         chk_byte("sig", n, 8'hFF, got[n]);
      end
      chk_byte("fas", 16, 8'h9B, got[16]);
      chk_byte("nfas", 17, 8'hDF, got[17]);
      chk_byte("status", 18, 8'h6C, got[18]);
      $display("test alarms done");
   endtask : test_alarms

   // Prints the counts and the verdict, then ends the run
   task automatic test_done();
      $display("checks %0d mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : test_done

   // Main sequence
   initial begin
      rst             = 1'b1;
      frame_sync_ok   = 1'b1;
      mframe_sync_ok  = 1'b1;
      fas_word_err    = 1'b0;
      slip_event      = 1'b0;
      ext_status      = 1'b0;
      fails           = 0;
      samples_checked = 0;
      cycles          = 0;
      repeat (2) @(posedge core_clk);
      rst <= 1'b0;
      test_idle();
      test_overhead();
      test_alarms();
      test_done();
   end
endmodule : e1_rx_overhead_status_report_tb_top
